/* common/dised_pkg.sv */
// dised_pkg: shared constants and types for the digital input edge counter
// assumes a single 100 MHz clock domain and register-port access
package dised_pkg;
  // register word offsets on the plain register port
  localparam logic [5:0] ADDR_STATE_WORD = 6'h00; // slot state word
  localparam logic [5:0] ADDR_CH_SEL = 6'h01; // selected channel
  localparam logic [5:0] ADDR_EDGE_CFG = 6'h02; // edge select of sel ch
  localparam logic [5:0] ADDR_COUNT = 6'h03; // count of sel ch, read
  localparam logic [5:0] ADDR_COUNT_CLR = 6'h04; // read-and-clear count
  localparam logic [5:0] ADDR_PRESET = 6'h05; // preset value, write loads
  localparam logic [5:0] ADDR_CH_STATE = 6'h06; // state bit of sel ch
  localparam logic [5:0] ADDR_CONFIG = 6'h07; // function config / reset
  localparam logic [5:0] ADDR_INT_CTRL = 6'h08; // interrupt enables
  localparam logic [5:0] ADDR_INT_STAT = 6'h09; // pending flags, w1c
  localparam logic [5:0] ADDR_RPT_CNT = 6'h0A; // repeat count for word
  // field positions
  localparam int CFG_SLOT_RST_BIT = 1;
  localparam int INT_ANY_EVT_BIT = 0;
  localparam int INT_ANY_OVF_BIT = 1;
  // reset values
  localparam logic [31:0] COUNT_RST = 32'h0000_0000;
  localparam logic [31:0] PRESET_DEFAULT = 32'h0000_0000;
  // synchroniser depth, cycles
  localparam int SYNC_STAGES = 2;

  typedef enum logic [1:0] {
    DISED_EDGE_IDLE,
    DISED_EDGE_RISE,
    DISED_EDGE_FALL,
    DISED_EDGE_BOTH
  } dised_edge_t;

  // one channel's edge pulses
  typedef struct packed {
    logic rise;
    logic fall;
  } dised_edges_t;

  // counter control for one channel
  typedef struct packed {
    logic load;
    logic clear;
    logic [31:0] value;
  } dised_cnt_ctl_t;
endpackage

/* rtl/dised_counter.sv */
// dised_counter: 32-bit signed edge counter with preset and clear
// assumes load and clear are single-cycle pulses on ref_clk
`timescale 1ns/100ps
module dised_counter (
  input wire logic ref_clk,
  input wire logic nrst,
  input wire logic count_en,
  input dised_pkg::dised_cnt_ctl_t ctl,
  output logic [31:0] count,
  output logic rollover
);
  logic [31:0] count_r;
  logic [31:0] base;
  logic [31:0] count_nxt;

  ////////////////////////////////////////////////////////////////////////
  // load or clear first, then the edge on top, so none is lost
  assign base = ctl.load ? ctl.value : (ctl.clear ? 32'h0000_0000 :
                count_r); // RL22
  assign count_nxt = count_en ? base + 32'h0000_0001 : base; // RL14
  // -1 to 0 step is the rollover event
  assign rollover = count_en & (base == 32'hFFFF_FFFF); // RL16
  assign count = count_r;

  // natural 32-bit wrap covers max positive to most negative
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      count_r <= dised_pkg::COUNT_RST;
    end else begin
      count_r <= count_nxt; // RL13
    end
  end
endmodule // dised_counter

/* rtl/dised_sync_edge.sv */
// dised_sync_edge: two-flop synchroniser and edge detector for one input
// assumes the input is already debounced and level-stable per transition
`timescale 1ns/100ps
module dised_sync_edge (
  input wire logic ref_clk,
  input wire logic nrst,
  input wire logic pin_in,
  output logic state,
  output dised_pkg::dised_edges_t edges
);
  logic meta_r;
  logic sync_r;
  logic prev_r;

  ////////////////////////////////////////////////////////////////////////
  // first flop feeds only the second flop
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      meta_r <= 1'b0;
      sync_r <= 1'b0;
      prev_r <= 1'b0;
    end else begin
      meta_r <= pin_in;
      sync_r <= meta_r; // RL21
      prev_r <= sync_r;
    end
  end

  // every transition gives one pulse, whatever the select says
  assign state = sync_r; // RL1
  assign edges.rise = sync_r & ~prev_r; // RL6
  assign edges.fall = ~sync_r & prev_r; // RL6
endmodule // dised_sync_edge

/* rtl/dised_top.sv */
// dised_top: digital input state sensing and edge counting, one slot
// assumes debounced inputs on pins, plain register port on ref_clk
//
// Summary of operation
// RL1: input high or present reads as state 1, low or absent as 0.
// RL2: single-channel query of a state channel returns its state bit.
// RL3: slot read returns all channel states as one word, no counts.
// RL4: repeat count on slot read resamples the word that many times.
// RL5: edge select is rising, falling, both, or idle.
// RL6: all transitions detected; only matching ones are counted.
// RL7: single-channel query of a counter returns count undisturbed.
// RL8: read-and-clear returns count and zeroes it atomically.
// RL9: list query yields states only, never counter contents.
// RL10: reset or slot reset forces every edge select to idle.
// RL11: one shared edge select per physical channel, both views.
// RL12: any-channel event selector raises event on programmed edge.
// RL13: each channel has its own 32-bit two's-complement counter.
// RL14: counter adds one per qualifying edge.
// RL15: preset loads a signed value; missing value loads zero.
// RL16: counter wraps max to min; -1 to 0 is the rollover.
// RL17: host presets minus N to roll over after N counts.
// RL18: state word bit 0 is lowest channel, top bit highest.
// RL19: function config disables interrupts, sets rising, presets 0.
// RL20: enabled counter interrupt fires on counter overflow.
// RL21: inputs are synchronised so each transition gives one pulse.
// RL22: preset or clear beats a same-cycle edge, edge counted after.
//
// Design decisions made here: the placing of the registers and the plain strobed port.
`timescale 1ns/100ps
module dised_top #(
  parameter int NUM_CH = 16
) (
  input wire logic ref_clk,
  input wire logic nrst,
  input wire logic [NUM_CH-1:0] din,
  input wire logic [5:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  output logic [NUM_CH-1:0] state_out,
  output logic event_irq,
  output logic counter_irq,
  output logic word_valid
);
  localparam int CW = $clog2(NUM_CH);

  logic [NUM_CH-1:0] state;
  logic [NUM_CH-1:0] qual;
  logic [NUM_CH-1:0] roll;
  logic [31:0] count [NUM_CH];
  logic [1:0] edge_sel_r [NUM_CH];
  logic [CW:0] ch_sel_r;
  logic [CW-1:0] ch_idx;
  logic sel_is_state;
  logic [1:0] int_en_r;
  logic [1:0] int_stat_r;
  logic [NUM_CH-1:0] ovf_en_r;
  logic [31:0] rdata_r;
  logic [NUM_CH-1:0] state_out_r;
  logic event_irq_r;
  logic counter_irq_r;
  logic word_valid_r;
  logic [31:0] rpt_left_r;
  logic [31:0] rpt_left_nxt;
  logic [31:0] rd_mux;

  ////////////////////////////////////////////////////////////////////////
  // decode of the plain register port
  wire wr_sel = reg_wr & (reg_addr == dised_pkg::ADDR_CH_SEL);
  wire wr_edge = reg_wr & (reg_addr == dised_pkg::ADDR_EDGE_CFG);
  wire wr_preset = reg_wr & (reg_addr == dised_pkg::ADDR_PRESET);
  wire wr_config = reg_wr & (reg_addr == dised_pkg::ADDR_CONFIG);
  wire wr_int_ctrl = reg_wr & (reg_addr == dised_pkg::ADDR_INT_CTRL);
  wire wr_int_stat = reg_wr & (reg_addr == dised_pkg::ADDR_INT_STAT);
  wire wr_rpt = reg_wr & (reg_addr == dised_pkg::ADDR_RPT_CNT);
  wire rd_clr = reg_rd & (reg_addr == dised_pkg::ADDR_COUNT_CLR);
  wire slot_rst = wr_config & reg_wdata[dised_pkg::CFG_SLOT_RST_BIT];
  wire fn_cfg = wr_config & ~reg_wdata[dised_pkg::CFG_SLOT_RST_BIT];

  // channels 0..N-1 are counters, N..2N-1 the same pins as states
  assign sel_is_state = ch_sel_r[CW];
  assign ch_idx = ch_sel_r[CW-1:0];

  ////////////////////////////////////////////////////////////////////////
  // per-channel sync, edge qualify, counter and edge select
  for (genvar i = 0; i < NUM_CH; i++) begin : g_ch
    dised_pkg::dised_edges_t edges;
    dised_pkg::dised_cnt_ctl_t ctl;
    wire this_ch = (ch_idx == CW'(i));

    dised_sync_edge u_sync (
      .ref_clk(ref_clk),
      .nrst(nrst),
      .pin_in(din[i]),
      .state(state[i]),
      .edges(edges)
    );

    // only the edges matching the select reach the counter
    assign qual[i] = (edge_sel_r[i] == 2'h1 && edges.rise) ||
                     (edge_sel_r[i] == 2'h2 && edges.fall) ||
                     (edge_sel_r[i] == 2'h3 && (edges.rise ||
                      edges.fall)); // RL5 RL6

    // preset via either view, config presets to zero
    assign ctl.load = (wr_preset & this_ch) | (fn_cfg & this_ch) |
                      slot_rst; // RL15 RL19
    assign ctl.value = (wr_preset & this_ch) ? reg_wdata :
                       dised_pkg::PRESET_DEFAULT; // RL15
    assign ctl.clear = rd_clr & this_ch & ~sel_is_state; // RL8

    dised_counter u_cnt (
      .ref_clk(ref_clk),
      .nrst(nrst),
      .count_en(qual[i]),
      .ctl(ctl),
      .count(count[i]),
      .rollover(roll[i])
    );

    // one select per pin, written through either view
    always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
        edge_sel_r[i] <= 2'h0; // RL10
      end else if (slot_rst) begin
        edge_sel_r[i] <= 2'h0; // RL10
      end else if (fn_cfg && this_ch) begin
        edge_sel_r[i] <= 2'h1; // RL19
      end else if (wr_edge && this_ch) begin
        edge_sel_r[i] <= reg_wdata[1:0]; // RL11
      end
    end

    // per-channel overflow enable, dropped by config
    always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
        ovf_en_r[i] <= 1'b0;
      end else if (slot_rst || (fn_cfg && this_ch)) begin
        ovf_en_r[i] <= 1'b0; // RL19
      end else if (wr_int_ctrl && this_ch) begin
        ovf_en_r[i] <= reg_wdata[2];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // read mux; count read leaves the counter alone
  always_comb begin
    rd_mux = 32'h0000_0000;
    case (reg_addr)
      dised_pkg::ADDR_STATE_WORD: begin
        // sign-extended state word, lowest channel in bit 0
        rd_mux = {{(32-NUM_CH){state[NUM_CH-1]}}, state}; // RL3 RL18
      end
      dised_pkg::ADDR_CH_SEL: rd_mux = {{(31-CW){1'b0}}, ch_sel_r};
      dised_pkg::ADDR_EDGE_CFG: rd_mux = {30'h0, edge_sel_r[ch_idx]};
      dised_pkg::ADDR_COUNT: begin
        // list-style reads of a state view never expose counts
        rd_mux = sel_is_state ? {31'h0, state[ch_idx]} :
                 count[ch_idx]; // RL7 RL9
      end
      dised_pkg::ADDR_COUNT_CLR: begin
        rd_mux = sel_is_state ? {31'h0, state[ch_idx]} :
                 count[ch_idx]; // RL8
      end
      dised_pkg::ADDR_CH_STATE: rd_mux = {31'h0, state[ch_idx]}; // RL2
      dised_pkg::ADDR_INT_CTRL: rd_mux = {29'h0, ovf_en_r[ch_idx],
                                          int_en_r};
      dised_pkg::ADDR_INT_STAT: rd_mux = {30'h0, int_stat_r};
      dised_pkg::ADDR_RPT_CNT: rd_mux = rpt_left_r;
      default: rd_mux = 32'h0000_0000;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////
  // channel select and slot-wide interrupt enables
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      ch_sel_r <= '0;
      int_en_r <= 2'h0;
    end else begin
      if (wr_sel) begin
        ch_sel_r <= reg_wdata[CW:0];
      end
      if (slot_rst || fn_cfg) begin
        int_en_r <= 2'h0; // RL19
      end else if (wr_int_ctrl) begin
        int_en_r <= reg_wdata[1:0];
      end
    end
  end

  // sticky flags: hardware set wins over a same-cycle w1c
  wire evt_hit = int_en_r[dised_pkg::INT_ANY_EVT_BIT] &
                 (|qual); // RL12
  wire ovf_hit = (int_en_r[dised_pkg::INT_ANY_OVF_BIT] & (|roll)) |
                 (|(roll & ovf_en_r)); // RL20
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      int_stat_r <= 2'h0;
    end else if (slot_rst || fn_cfg) begin
      int_stat_r <= 2'h0; // RL19
    end else begin
      int_stat_r <= (int_stat_r & ~(wr_int_stat ? reg_wdata[1:0] : 2'h0))
                    | {ovf_hit, evt_hit};
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // repeated sampling of the state word, one sample per cycle
  assign rpt_left_nxt = wr_rpt ? reg_wdata :
                        (rpt_left_r != 32'h0 ? rpt_left_r - 32'h1 :
                         32'h0); // RL4
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      rpt_left_r <= 32'h0;
      word_valid_r <= 1'b0;
      state_out_r <= '0;
    end else begin
      rpt_left_r <= rpt_left_nxt;
      word_valid_r <= (rpt_left_r != 32'h0) & ~wr_rpt; // RL4
      state_out_r <= state; // RL3
    end
  end

  // registered outputs
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      rdata_r <= 32'h0;
      event_irq_r <= 1'b0;
      counter_irq_r <= 1'b0;
    end else begin
      rdata_r <= reg_rd ? rd_mux : 32'h0;
      event_irq_r <= int_stat_r[dised_pkg::INT_ANY_EVT_BIT];
      counter_irq_r <= int_stat_r[dised_pkg::INT_ANY_OVF_BIT];
    end
  end

  assign reg_rdata = rdata_r;
  assign state_out = state_out_r;
  assign event_irq = event_irq_r;
  assign counter_irq = counter_irq_r;
  assign word_valid = word_valid_r;
endmodule // dised_top

/* test/dised_chk_assertions.sv */
// dised_chk: port-level properties of the edge counter slot
// assumes one ref_clk domain, nrst asynchronous active low
`timescale 1ns/100ps
module dised_chk #(
  parameter int NUM_CH = 16
) (
  input wire logic ref_clk,
  input wire logic nrst,
  input wire logic [NUM_CH-1:0] din,
  input wire logic [5:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [31:0] reg_rdata,
  input wire logic [NUM_CH-1:0] state_out,
  input wire logic event_irq,
  input wire logic counter_irq,
  input wire logic word_valid
);
  logic [NUM_CH-1:0] din_r;
  logic [2:0] quiet_r;
  logic [2:0] quiet_nxt;
  // a change seen this cycle breaks quiet at once, before the count drops
  wire quiet = (quiet_r == 3'h7) && (din == din_r);
  wire [31:0] word_w = {{(32-NUM_CH){din[NUM_CH-1]}}, din};
  // quiet once din has held long enough for sync and edge stages
  assign quiet_nxt = (din != din_r) ? 3'h0 : quiet_r + {2'h0, !quiet};
  // helper only, never compared directly
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      din_r <= '0;
      quiet_r <= 3'h0;
    end else begin
      din_r <= din;
      quiet_r <= quiet_nxt;
    end
  end
  //////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!nrst);
  sequence s_rd(a);
    reg_rd && reg_addr == a;
  endsequence
  // clear then read; edges held off by quiet so zero is exact
  sequence s_clr_rd;
    quiet ##0 s_rd(dised_pkg::ADDR_COUNT_CLR) ##1 s_rd(dised_pkg::ADDR_COUNT);
  endsequence
  a_rdata_idle: assert property (!reg_rd |=> reg_rdata == 32'h0)
    else $error("read data not zero outside a read");
  a_state_follow: assert property (quiet |-> state_out == din)
    else $error("state does not follow settled input");
  a_word_read: assert property (quiet
    ##0 s_rd(dised_pkg::ADDR_STATE_WORD) |=> reg_rdata == $past(word_w))
    else $error("state word wrong");
  a_slot_reset: assert property (reg_wr
    && reg_addr == dised_pkg::ADDR_CONFIG
    && reg_wdata[dised_pkg::CFG_SLOT_RST_BIT]
    |-> ##2 !event_irq && !counter_irq)
    else $error("interrupt survives slot reset");
  a_clear_zero: assert property (s_clr_rd |=> reg_rdata == 32'h0)
    else $error("count not zero after read and clear");
  a_count_hold: assert property (quiet ##0 s_rd(dised_pkg::ADDR_COUNT)
    ##1 s_rd(dised_pkg::ADDR_COUNT) |=> $stable(reg_rdata))
    else $error("count changed by a plain read");
  a_preset_load: assert property (quiet && reg_wr
    && reg_addr == dised_pkg::ADDR_PRESET ##1 s_rd(dised_pkg::ADDR_COUNT)
    |=> reg_rdata == $past(reg_wdata, 2)) else $error("preset not loaded");
  a_unmapped_zero: assert property (reg_rd
    && reg_addr > dised_pkg::ADDR_RPT_CNT |=> reg_rdata == 32'h0)
    else $error("unmapped read not zero");
endmodule // dised_chk
bind dised_top dised_chk #(.NUM_CH(NUM_CH)) dised_chk_i (.ref_clk(ref_clk),
  .nrst(nrst), .din(din), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
  .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
  .state_out(state_out), .event_irq(event_irq), .counter_irq(counter_irq),
  .word_valid(word_valid));

/* test/dised_host_model.sv */
// dised_host_model: controller side, one register access per cycle
// assumes callers enter each task just after a rising ref_clk edge
`timescale 1ns/100ps
module dised_host_model (
  input wire logic ref_clk,
  output logic [5:0] reg_addr,
  output logic [31:0] reg_wdata,
  output logic reg_wr,
  output logic reg_rd
);
  // quiet bus from time zero
  initial begin
    reg_addr = 6'h00;
    reg_wdata = 32'h0;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
  end
  // strobes are not lowered here, so back-to-back calls never glitch
  task automatic wr(input logic [5:0] a, input logic [31:0] d);
    reg_wr <= 1'b1;
    reg_rd <= 1'b0;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge ref_clk);
  endtask
  task automatic rd(input logic [5:0] a);
    reg_wr <= 1'b0;
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge ref_clk);
  endtask
  task automatic idle();
    reg_wr <= 1'b0;
    reg_rd <= 1'b0;
    @(posedge ref_clk);
  endtask
endmodule // dised_host_model

/* test/testbench.sv */
// testbench: register-port scenarios for one 16-channel slot
// assumes dised_chk bound in and dised_host_model as bus master
`timescale 1ns/100ps
module testbench;
  localparam int N = 16;
  logic ref_clk = 1'b0;
  logic nrst = 1'b0;
  logic [N-1:0] din = '0;
  logic [5:0] reg_addr;
  logic [31:0] reg_wdata;
  logic reg_wr;
  logic reg_rd;
  logic [31:0] reg_rdata;
  logic [N-1:0] state_out;
  logic event_irq;
  logic counter_irq;
  logic word_valid;
  logic rd_d = 1'b0;
  logic [31:0] exp_q[$];
  int failures = 0;
  int total_checks = 0;
  int wv_n = 0;
  int ch;
  logic [31:0] pv;
  always #5 ref_clk = ~ref_clk;
  dised_top #(.NUM_CH(N)) dised_top_i (.ref_clk(ref_clk), .nrst(nrst),
    .din(din), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .state_out(state_out),
    .event_irq(event_irq), .counter_irq(counter_irq),
    .word_valid(word_valid));
  dised_host_model dised_host_model_i (.ref_clk(ref_clk),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd));
  //////////////////////////////////////////////////////////////////////////
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      failures++;
      $display("ERROR %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic complete_run();
    $display("checks %0d failures %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  // note the expectation first; the monitor pops it a cycle later
  task automatic rd(input logic [5:0] a, input logic [31:0] e);
    exp_q.push_back(e);
    dised_host_model_i.rd(a);
  endtask
  task automatic wr(input logic [5:0] a, input logic [31:0] d);
    dised_host_model_i.wr(a, d);
  endtask
  task automatic idle(input int n);
    repeat (n) dised_host_model_i.idle();
  endtask
  // 8 idle cycles covers sync, edge and settle stages
  task automatic pulse();
    din[ch] <= 1'b1;
    idle(8);
    din[ch] <= 1'b0;
    idle(8);
  endtask
  //////////////////////////////////////////////////////////////////////////
  // read data stands only in the cycle after the strobe
  always @(posedge ref_clk) begin
    if (rd_d) check(reg_rdata, exp_q.pop_front());
    rd_d <= reg_rd;
    if (word_valid) begin
      wv_n++;
      check(32'(state_out), 32'(din));
    end
  end
  // hang guard, far beyond the few hundred cycles needed
  initial begin
    repeat (20000) @(posedge ref_clk);
    failures++;
    complete_run();
  end
  initial begin
    void'($urandom(32'h170B));
    repeat (4) @(posedge ref_clk);
    nrst <= 1'b1;
    @(posedge ref_clk);
    for (int c = 0; c < N; c++) begin
      wr(dised_pkg::ADDR_CH_SEL, c);
      rd(dised_pkg::ADDR_EDGE_CFG, 32'h0);
      rd(dised_pkg::ADDR_COUNT, 32'h0);
    end
    $display("test reset done");
    ch = $urandom_range(N - 1, 0);
    wr(dised_pkg::ADDR_CH_SEL, ch);
    for (int m = 0; m < 4; m++) begin
      wr(dised_pkg::ADDR_EDGE_CFG, m);
      wr(dised_pkg::ADDR_PRESET, 32'h0);
      pulse();
      rd(dised_pkg::ADDR_COUNT, (m == 3) ? 32'h2 : 32'(m != 0));
    end
    wr(dised_pkg::ADDR_EDGE_CFG, 32'h1);
    pulse();
    rd(dised_pkg::ADDR_COUNT, 32'h3);
    rd(dised_pkg::ADDR_COUNT, 32'h3);
    rd(dised_pkg::ADDR_COUNT_CLR, 32'h3);
    rd(dised_pkg::ADDR_COUNT, 32'h0);
    pv = $urandom;
    wr(dised_pkg::ADDR_PRESET, pv);
    rd(dised_pkg::ADDR_COUNT, pv);
    wr(dised_pkg::ADDR_PRESET, 32'h7FFF_FFFF);
    pulse();
    rd(dised_pkg::ADDR_COUNT, 32'h8000_0000);
    $display("test counting done");
    wr(dised_pkg::ADDR_INT_CTRL, 32'h4);
    wr(dised_pkg::ADDR_PRESET, 32'hFFFF_FFFE);
    pulse();
    check({31'h0, counter_irq}, 32'h0);
    pulse();
    rd(dised_pkg::ADDR_COUNT, 32'h0);
    check({31'h0, counter_irq}, 32'h1);
    wr(dised_pkg::ADDR_INT_STAT, 32'h2);
    idle(3);
    check({31'h0, counter_irq}, 32'h0);
    $display("test rollover done");
    wr(dised_pkg::ADDR_CH_SEL, N + ch);
    wr(dised_pkg::ADDR_EDGE_CFG, 32'h2);
    wr(dised_pkg::ADDR_INT_CTRL, 32'h1);
    din[ch] <= 1'b1;
    idle(8);
    rd(dised_pkg::ADDR_CH_STATE, 32'h1);
    rd(dised_pkg::ADDR_COUNT, 32'h1);
    check({31'h0, event_irq}, 32'h0);
    din[ch] <= 1'b0;
    idle(8);
    check({31'h0, event_irq}, 32'h1);
    wr(dised_pkg::ADDR_CH_SEL, ch);
    rd(dised_pkg::ADDR_EDGE_CFG, 32'h2);
    $display("test state and event done");
    din <= N'($urandom);
    idle(8);
    rd(dised_pkg::ADDR_STATE_WORD, {{(32 - N){din[N-1]}}, din});
    wr(dised_pkg::ADDR_RPT_CNT, 32'h3);
    idle(8);
    check(32'(wv_n), 32'h3);
    rd(6'h3F, 32'h0);
    $display("test word done");
    wr(dised_pkg::ADDR_CONFIG, 32'h0);
    rd(dised_pkg::ADDR_EDGE_CFG, 32'h1);
    rd(dised_pkg::ADDR_COUNT, 32'h0);
    rd(dised_pkg::ADDR_INT_CTRL, 32'h0);
    check({31'h0, event_irq}, 32'h0);
    // both edges, so the pulse flags whatever level din was left at
    wr(dised_pkg::ADDR_EDGE_CFG, 32'h3);
    wr(dised_pkg::ADDR_INT_CTRL, 32'h1);
    pulse();
    check({31'h0, event_irq}, 32'h1);
    wr(dised_pkg::ADDR_CONFIG, 32'h2);
    idle(2);
    check({31'h0, event_irq}, 32'h0);
    rd(dised_pkg::ADDR_EDGE_CFG, 32'h0);
    idle(3);
    $display("test config done");
    complete_run();
  end
endmodule // testbench
